/* common/hostif_pkg.sv */
// Shared constants and types for the host interface selector.
package hostif_pkg;

  // ==========================================================
  // Timing
  localparam int CLOCK_HZ = 10_000_000;
  localparam int IDLE_TIMEOUT_S = 10;
  localparam int IDLE_CYCLES = CLOCK_HZ * IDLE_TIMEOUT_S;
  localparam int SLOW_RATE_BPS = 2;
  localparam int SLOW_CYCLES = CLOCK_HZ / SLOW_RATE_BPS;

  // ==========================================================
  // Receive buffer free-space thresholds in bytes
  localparam logic [19:0] FREE_SLOW_BELOW = 20'h04000;
  localparam logic [19:0] FREE_OPEN_ABOVE = 20'h08000;
  localparam logic [19:0] FREE_HALT_AT = 20'h00010;
  localparam logic [19:0] FREE_RESUME_AT = 20'h80000;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATAIN = 8'h08;
  localparam logic [7:0] REG_STRING = 8'h0c;

  // ==========================================================
  // Option card command codes with special handling
  localparam logic [7:0] OPT_NOP = 8'h00;
  localparam logic [7:0] OPT_HW_RESET = 8'h01;
  localparam logic [7:0] OPT_INQ_NAME = 8'h05;
  localparam logic [7:0] OPT_COMPLETE = 8'h08;
  localparam logic [7:0] OPT_STOP = 8'h09;
  localparam logic [7:0] OPT_INQ_URGENT = 8'h14;

  // Main commands sent to the card.
  localparam logic [7:0] MAIN_SOFT_RESET = 8'h01;
  localparam logic [7:0] MAIN_NAME_DATA = 8'h04;
  localparam logic [7:0] MAIN_INQ_EMUL = 8'h07;
  localparam logic [7:0] MAIN_INQ_ASCII = 8'h0e;
  localparam logic [7:0] MAIN_URG_REPLY = 8'h14;
  localparam logic [7:0] MAIN_URG_MSG = 8'h15;

  // Urgent command values.
  localparam logic [7:0] URG_DEVICE_ID = 8'h00;
  localparam logic [7:0] URG_ALL_STATUS = 8'h01;
  localparam logic [7:0] URG_JOB_INFO = 8'h08;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {PORT_NONE, PORT_PAR, PORT_USB, PORT_OPT} port_t;
  typedef enum logic [1:0] {RA_ACCEPT, RA_REJECT, RA_UNKNOWN,
                            RA_RESERVED} reply_a_t;
  typedef enum logic [1:0] {RB_NONE, RB_EXEC_OK, RB_CHECK} reply_b_t;
  typedef enum logic [1:0] {TH_OPEN, TH_SLOW, TH_HALT} throttle_t;

  typedef struct packed {
    logic offline;
    logic nibbleEcp;
    port_t manualPort;
    logic autoSel;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{offline: 1'b0, nibbleEcp: 1'b0,
                                   manualPort: PORT_PAR, autoSel: 1'b1};

  typedef struct packed {
    reply_a_t replyA;
    reply_b_t replyB;
  } opt_reply_t;

  // Pending main command slots, lowest index sent first.
  localparam int PEND_N = 6;
  localparam logic [PEND_N-1:0] PEND_RESET = 6'h01;

endpackage

/* core/host_interface_select.sv */
// Host port selector, receive throttle and option card command logic.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// ==========================================================
// Byte FIFO in the receive path.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // Full and empty come straight from the occupancy count.
  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];

  // Pointer and count update.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset.
  always_ff @(posedge clock) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule

// ==========================================================
// Function
// - Classify option codes: accept, reject, unknown, reserved.
// - Second reply: execute-OK, check, or none.
// - Soft reset to card on init, 01h, panel, cold.
// - Main commands on name, emulation, data-in, urgent.
// - State-reply on: stream status, mark start/end.
// - Decode urgent values 00h, 01h, 08h.
// - Low free space: throttle parallel and option card to two bytes/second.
// - Lift above 32k, halt at 16, resume at 512k.
// - Manual mode uses exactly one configured port.
// - Auto mode picks first port delivering data.
// - Auto mode: ten idle seconds deselect port.
// - Unselected parallel port is held busy.
// - Idle: parallel ready, USB no NACK, offline cleared.
// - Ignore INIT when unselected or nibble/ECP.
module host_interface_select
  import hostif_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES,
  parameter int SLOW_LIMIT = SLOW_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB register bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parallel port pins
  input wire logic [7:0] parData,
  input wire logic parStrobe,
  input wire logic parInit,
  output logic parBusy,
  // USB byte stream
  input wire logic usbValid,
  input wire logic [7:0] usbData,
  output logic usbReady,
  output logic usbNack,
  // Option card data and commands
  input wire logic optValid,
  input wire logic [7:0] optData,
  output logic optReady,
  input wire logic optCmdValid,
  input wire logic [7:0] optCmd,
  output logic replyValid,
  output opt_reply_t reply,
  output logic mainCmdValid,
  output logic [7:0] mainCmd,
  output logic cardDataInValid,
  output logic [7:0] cardDataIn,
  output logic cardOffline,
  input wire logic stateReplyValid,
  input wire logic stateReplyOn,
  input wire logic urgentValid,
  input wire logic [7:0] urgentCode,
  input wire logic urgentReplyDone,
  output logic urgentDeviceId,
  output logic urgentAllStatus,
  output logic urgentJobInfo,
  // Printer events and buffer state
  input wire logic panelReset,
  input wire logic emulationChange,
  input wire logic errorPresent,
  input wire logic [19:0] bufFree,
  // Received data towards the printer
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady
);
  ctrl_t ctrl;
  port_t sel;
  throttle_t th;
  throttle_t next_th;
  logic [1:0] strobeSync;
  logic [1:0] initSync;
  logic [7:0] dataMeta;
  logic [7:0] dataSync;
  logic strobeLast;
  logic initLast;
  logic parFull;
  logic [7:0] parHold;
  logic [31:0] idleCnt;
  logic [31:0] slowCnt;
  logic slowCredit;
  logic stateReply;
  logic [PEND_N-1:0] pend;
  logic [PEND_N-1:0] ev;
  logic fifoInReady;

  // ==========================================================
  // Pin synchronisers and edge detection on the second stage.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strobeSync <= '0;
      initSync <= '0;
      dataMeta <= '0;
      dataSync <= '0;
      strobeLast <= 1'b0;
      initLast <= 1'b0;
    end else begin
      strobeSync <= {strobeSync[0], parStrobe};
      initSync <= {initSync[0], parInit};
      dataMeta <= parData;
      dataSync <= dataMeta;
      strobeLast <= strobeSync[1];
      initLast <= initSync[1];
    end
  end

  wire strobeRise = strobeSync[1] && !strobeLast;
  wire initRise = initSync[1] && !initLast;

  // ==========================================================
  // Port selection and data acceptance.
  wire autoIdle = ctrl.autoSel && sel == PORT_NONE;
  wire parOpen = sel == PORT_PAR || autoIdle;
  wire parCatch = strobeRise && !parFull && parOpen;
  wire throttleOk = th == TH_OPEN || (th == TH_SLOW && slowCredit);
  wire takePar = sel == PORT_PAR && parFull && fifoInReady && throttleOk;
  wire takeUsb = sel == PORT_USB && usbValid && fifoInReady;
  wire takeOpt = sel == PORT_OPT && optValid && fifoInReady && throttleOk;
  wire take = takePar || takeUsb || takeOpt;
  wire [7:0] takeData = takePar ? parHold : (takeUsb ? usbData : optData);
  wire idleExpire = ctrl.autoSel && sel != PORT_NONE &&
                    idleCnt == 32'(IDLE_LIMIT - 1);
  // Ready and busy follow the selection; the USB side never NACKs in idle.
  assign usbReady = takeUsb;
  assign optReady = takeOpt;
  assign parBusy = parFull || !parOpen;
  assign usbNack = sel != PORT_NONE && sel != PORT_USB;

  // Selection register: manual forces the configured port.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel <= PORT_NONE;
    end else if (!ctrl.autoSel) begin
      sel <= ctrl.manualPort;
    end else if (idleExpire) begin
      sel <= PORT_NONE;
    end else if (sel == PORT_NONE) begin
      if (parFull) sel <= PORT_PAR;
      else if (usbValid) sel <= PORT_USB;
      else if (optValid) sel <= PORT_OPT;
    end
  end

  // Parallel byte holding latch, released into the FIFO.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      parFull <= 1'b0;
      parHold <= '0;
    end else if (parCatch) begin
      parFull <= 1'b1;
      parHold <= dataSync;
    end else if (takePar) begin
      parFull <= 1'b0;
    end
  end

  // Idle timer counts only while a port is held in auto mode.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) idleCnt <= '0;
    else if (!ctrl.autoSel || sel == PORT_NONE || take) idleCnt <= '0;
    else if (!idleExpire) idleCnt <= idleCnt + 1'b1;
  end

  // ==========================================================
  // Throttle state from the free space of the receive buffer.
  always_comb begin
    next_th = th;
    case (th)
      TH_OPEN: begin
        if (bufFree <= FREE_HALT_AT) next_th = TH_HALT;
        else if (!errorPresent && bufFree < FREE_SLOW_BELOW)
          next_th = TH_SLOW;
      end
      TH_SLOW: begin
        if (bufFree <= FREE_HALT_AT) next_th = TH_HALT;
        else if (bufFree > FREE_OPEN_ABOVE || errorPresent)
          next_th = TH_OPEN;
      end
      TH_HALT: begin
        if (bufFree >= FREE_RESUME_AT) next_th = TH_SLOW;
      end
      default: next_th = TH_OPEN;
    endcase
  end

  // Slow-rate credit: one byte per interval.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      th <= TH_OPEN;
      slowCnt <= '0;
      slowCredit <= 1'b0;
    end else begin
      th <= next_th;
      if (th != TH_SLOW || (take && !takeUsb)) begin
        slowCnt <= '0;
        slowCredit <= 1'b0;
      end else if (slowCnt == 32'(SLOW_LIMIT - 1)) begin
        slowCredit <= 1'b1;
      end else begin
        slowCnt <= slowCnt + 1'b1;
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clock(clock),
    .rst(rst),
    .inValid(take),
    .inData(takeData),
    .inReady(fifoInReady),
    .outValid(rxValid),
    .outData(rxData),
    .outReady(rxReady)
  );

  // ==========================================================
  // APB slave with no wait states; all answers registered.
  wire setup = psel && !penable && !pready;
  wire wrDone = psel && penable && pready && pwrite;
  wire mapped = paddr == REG_CTRL || paddr == REG_STATUS ||
                paddr == REG_DATAIN || paddr == REG_STRING;
  wire wrCtrl = wrDone && paddr == REG_CTRL;
  wire wrDataIn = wrDone && paddr == REG_DATAIN;
  wire wrString = wrDone && paddr == REG_STRING;
  wire [31:0] readMux =
    (paddr == REG_CTRL) ? {27'h0000000, ctrl} :
    (paddr == REG_STATUS) ? {26'h0000000, parFull, stateReply, th, sel} :
    32'h00000000;

  // Bus answer registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? readMux : '0;
    end
  end

  // Control register; a software set of offline beats the idle clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) ctrl <= CTRL_RESET;
    else if (wrCtrl) ctrl <= ctrl_t'(pwdata[4:0]);
    else if (idleExpire) ctrl.offline <= 1'b0;
  end
  assign cardOffline = ctrl.offline;

  // Card data-in register and state-reply setting.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cardDataIn <= '0;
      cardDataInValid <= 1'b0;
      stateReply <= 1'b0;
    end else begin
      cardDataInValid <= wrDataIn;
      if (wrDataIn) cardDataIn <= pwdata[7:0];
      if (stateReplyValid) stateReply <= stateReplyOn;
    end
  end

  // ==========================================================
  // Option command replies.
  function automatic opt_reply_t classify(input logic [7:0] code);
    opt_reply_t r;
    r = '{replyA: RA_RESERVED, replyB: RB_NONE};
    case (code)
      8'h00, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0b, 8'h0c, 8'h0f, 8'h15:
        r.replyA = RA_ACCEPT;
      8'h02, 8'h04, 8'h0a, 8'h0d, 8'h0e: r.replyA = RA_REJECT;
      OPT_HW_RESET, OPT_INQ_URGENT: r = '{replyA: RA_ACCEPT,
                                          replyB: RB_EXEC_OK};
      OPT_STOP: r = '{replyA: RA_REJECT, replyB: RB_EXEC_OK};
      OPT_COMPLETE: r = '{replyA: RA_ACCEPT, replyB: RB_CHECK};
      default: begin
        if (code < 8'h20) r.replyA = RA_UNKNOWN;
      end
    endcase
    return r;
  endfunction

  wire opt_reply_t nextReply = classify(optCmd);

  // Reply and urgent decode pulses.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      replyValid <= 1'b0;
      reply <= '{replyA: RA_ACCEPT, replyB: RB_NONE};
      urgentDeviceId <= 1'b0;
      urgentAllStatus <= 1'b0;
      urgentJobInfo <= 1'b0;
    end else begin
      replyValid <= optCmdValid;
      if (optCmdValid) reply <= nextReply;
      urgentDeviceId <= urgentValid && urgentCode == URG_DEVICE_ID;
      urgentAllStatus <= urgentValid && urgentCode == URG_ALL_STATUS;
      urgentJobInfo <= urgentValid && urgentCode == URG_JOB_INFO;
    end
  end

  // ==========================================================
  // Main command events, one slot each, sent lowest slot first.
  wire initOk = initRise && sel == PORT_PAR && !ctrl.nibbleEcp;
  assign ev[0] = initOk || panelReset ||
                 (optCmdValid && optCmd == OPT_HW_RESET);
  assign ev[1] = optCmdValid && optCmd == OPT_INQ_NAME;
  assign ev[2] = emulationChange;
  assign ev[3] = wrDataIn || (wrString && stateReply);
  assign ev[4] = urgentReplyDone;
  assign ev[5] = urgentValid;
  wire [PEND_N-1:0] grant = pend & (~pend + 1'b1);

  function automatic logic [7:0] slotCode(input logic [PEND_N-1:0] g);
    logic [7:0] c;
    c = MAIN_URG_MSG;
    if (g[0]) c = MAIN_SOFT_RESET;
    else if (g[1]) c = MAIN_NAME_DATA;
    else if (g[2]) c = MAIN_INQ_EMUL;
    else if (g[3]) c = MAIN_INQ_ASCII;
    else if (g[4]) c = MAIN_URG_REPLY;
    return c;
  endfunction

  // Pending slots start with the cold-start reset; new events win over send.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend <= PEND_RESET;
      mainCmdValid <= 1'b0;
      mainCmd <= '0;
    end else begin
      pend <= (pend & ~grant) | ev;
      mainCmdValid <= |pend;
      mainCmd <= slotCode(grant);
    end
  end
endmodule

/* verif/hostif_properties.sv */
// Concurrent checks on the ports of the host interface selector.
`timescale 1ns/1ps
module hostif_properties
  import hostif_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Option card side
  input wire logic optCmdValid,
  input wire logic [7:0] optCmd,
  input wire opt_reply_t reply,
  input wire logic urgentValid,
  input wire logic [7:0] urgentCode,
  input wire logic urgentDeviceId,
  input wire logic urgentJobInfo,
  input wire logic mainCmdValid,
  input wire logic [7:0] mainCmd,
  input wire logic cardDataInValid,
  input wire logic optReady,
  // Host ports and buffer
  input wire logic usbReady,
  input wire logic parBusy,
  input wire logic [19:0] bufFree
);
  // ==========================================================
  // Clocking
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Properties
  property p_rsv;
    optCmdValid && optCmd >= 8'h20 |=>
      reply.replyA == RA_RESERVED && reply.replyB == RB_NONE;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Bad reserved reply.");
  property p_exec;
    optCmdValid && optCmd inside {8'h01, 8'h09, 8'h14} |=>
      reply.replyB == RB_EXEC_OK;
  endproperty
  a_exec: assert property (p_exec) else $error("No execute OK.");
  property p_job;
    urgentValid && urgentCode == URG_JOB_INFO |=>
      urgentJobInfo && !urgentDeviceId;
  endproperty
  a_job: assert property (p_job) else $error("Bad job decode.");
  property p_urg;
    urgentValid |-> ##[2:8] mainCmdValid && mainCmd == MAIN_URG_MSG;
  endproperty
  a_urg: assert property (p_urg) else $error("No urgent message.");
  property p_din;
    cardDataInValid |-> ##[1:8] mainCmdValid && mainCmd == MAIN_INQ_ASCII;
  endproperty
  a_din: assert property (p_din) else $error("No data-in notice.");
  property p_busy;
    usbReady |-> parBusy;
  endproperty
  a_busy: assert property (p_busy) else $error("Parallel not busy.");
  property p_cold;
    $fell(rst) |-> ##[0:2] mainCmdValid && mainCmd == MAIN_SOFT_RESET;
  endproperty
  a_cold: assert property (p_cold) else $error("No cold reset.");
  property p_halt;
    (bufFree <= FREE_HALT_AT) [*3] |-> !optReady;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt not kept.");
endmodule

bind host_interface_select hostif_properties u_props (
  .clock(clock), .rst(rst), .optCmdValid(optCmdValid), .optCmd(optCmd),
  .reply(reply), .urgentValid(urgentValid), .urgentCode(urgentCode),
  .urgentDeviceId(urgentDeviceId), .urgentJobInfo(urgentJobInfo),
  .mainCmdValid(mainCmdValid), .mainCmd(mainCmd),
  .cardDataInValid(cardDataInValid), .optReady(optReady),
  .usbReady(usbReady), .parBusy(parBusy), .bufFree(bufFree)
);

/* verif/tb_host_interface_select.sv */
// Self-checking bench for the host interface selector.
`timescale 1ns/1ps
module tb_host_interface_select
  import hostif_pkg::*;
;
  // ==========================================================
  // Signals
  localparam int IDLE = 50;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, optCmd, usbData, rxData, mainCmd, cardDataIn, uCode;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] ev;
  logic optCmdValid, rxReady, errorPresent, usbValid, usbReady, rxValid;
  logic replyValid, mainCmdValid, cardDataInValid, parBusy, usbNack;
  logic cardOffline, uId, uAll, uJob;
  logic parStrobe, optValid;
  logic [7:0] parData, optData;
  logic [19:0] bufFree;
  opt_reply_t reply;
  logic [20:0] thIn [9] = '{21'h004000, 21'h103fff, 21'h003fff,
    21'h008000, 21'h008001, 21'h003fff, 21'h000011, 21'h000010, 21'h07ffff};
  logic [1:0] thExp [9] = '{0, 0, 1, 1, 0, 1, 1, 2, 2};
  int mismatches = 0;
  int nCompared = 0;

  // ==========================================================
  // Design, partner and clock
  host_interface_select #(.IDLE_LIMIT(IDLE), .SLOW_LIMIT(20)) u_dut (
    .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parData(parData),
    .parStrobe(parStrobe), .parInit(ev[5]), .parBusy(parBusy),
    .usbValid(usbValid), .usbData(usbData), .usbReady(usbReady),
    .usbNack(usbNack), .optValid(optValid), .optData(optData), .optReady(),
    .optCmdValid(optCmdValid), .optCmd(optCmd), .replyValid(replyValid),
    .reply(reply), .mainCmdValid(mainCmdValid), .mainCmd(mainCmd),
    .cardDataInValid(cardDataInValid), .cardDataIn(cardDataIn),
    .cardOffline(cardOffline), .stateReplyValid(ev[4]),
    .stateReplyOn(1'b1), .urgentValid(ev[2]), .urgentCode(uCode),
    .urgentReplyDone(ev[3]), .urgentDeviceId(uId),
    .urgentAllStatus(uAll), .urgentJobInfo(uJob), .panelReset(ev[0]),
    .emulationChange(ev[1]), .errorPresent(errorPresent),
    .bufFree(bufFree), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady));
  usb_host_model u_host (.clock(clock), .usbReady(usbReady),
    .usbValid(usbValid), .usbData(usbData));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expMain(input logic [7:0] c);
    int i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 20 && !hit; i++) begin
      @(posedge clock);
      hit = (mainCmdValid === 1'b1 && mainCmd === c);
    end
    check({31'h0, hit}, 32'h1);
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
  endtask
  function automatic opt_reply_t expReply(input logic [7:0] c);
    opt_reply_t r;
    r.replyB = (c inside {8'h01, 8'h09, 8'h14}) ? RB_EXEC_OK :
               (c == 8'h08) ? RB_CHECK : RB_NONE;
    if (c >= 8'h20) r.replyA = RA_RESERVED;
    else if (c inside {8'h02, 8'h04, 8'h09, 8'h0a, 8'h0d, 8'h0e})
      r.replyA = RA_REJECT;
    else if (c inside {[8'h10:8'h13], [8'h16:8'h1f]}) r.replyA = RA_UNKNOWN;
    else r.replyA = RA_ACCEPT;
    return r;
  endfunction
  task automatic optSend(input logic [7:0] c);
    @(posedge clock);
    optCmdValid <= 1'b1;
    optCmd <= c;
    @(posedge clock);
    optCmdValid <= 1'b0;
    @(posedge clock);
    check({27'h0, replyValid, reply}, {27'h1, expReply(c)});
  endtask
  task automatic pop(input logic [7:0] e);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (rxValid !== 1'b1 && i < 20);
    check({23'h0, rxValid, rxData}, {23'h0, 1'b1, e});
    rxReady <= 1'b1;
    @(posedge clock);
    rxReady <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic afterReset();
    expMain(MAIN_SOFT_RESET);
    check({30'h0, parBusy, usbNack}, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h3);
    apb(1'b1, REG_STATUS, 32'hff);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask
  task automatic mainCommands();
    int i;
    pulse(0);
    expMain(MAIN_SOFT_RESET);
    optSend(OPT_INQ_NAME);
    expMain(MAIN_NAME_DATA);
    pulse(1);
    expMain(MAIN_INQ_EMUL);
    apb(1'b1, REG_DATAIN, 32'h41);
    @(posedge clock);
    check({23'h0, cardDataInValid, cardDataIn}, 32'h141);
    expMain(MAIN_INQ_ASCII);
    for (i = 0; i < 3; i++) begin
      uCode <= (i == 0) ? URG_DEVICE_ID : (i == 1) ? URG_ALL_STATUS :
               URG_JOB_INFO;
      pulse(2);
      @(posedge clock);
      check({29'h0, uId, uAll, uJob}, 32'h4 >> i);
      expMain(MAIN_URG_MSG);
    end
    pulse(3);
    expMain(MAIN_URG_REPLY);
    pulse(4);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[4]}, 32'h1);
    apb(1'b1, REG_STRING, 32'h0);
    expMain(MAIN_INQ_ASCII);
  endtask
  task automatic usbFifo();
    int i;
    int hi;
    u_host.send(8'h80);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h3, {30'h0, PORT_USB});
    check({30'h0, parBusy, usbNack}, 32'h2);
    pulse(5);
    for (i = 0; i < 12; i++) begin
      @(posedge clock);
      check({31'h0, mainCmdValid}, 32'h0);
    end
    for (i = 1; i < 8; i++) u_host.send(8'h80 + i[7:0]);
    fork
      u_host.send(8'h88);
    join_none
    hi = 0;
    repeat (6) begin
      @(posedge clock);
      hi += (usbReady === 1'b1);
    end
    check(hi, 0);
    for (i = 0; i < 9; i++) pop(8'h80 + i[7:0]);
  endtask
  task automatic idleTimer();
    apb(1'b1, REG_CTRL, 32'h13);
    @(posedge clock);
    check({31'h0, cardOffline}, 32'h1);
    u_host.send(8'h01);
    repeat (IDLE - 10) @(posedge clock);
    u_host.send(8'h02);
    repeat (IDLE - 10) @(posedge clock);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h3, {30'h0, PORT_USB});
    repeat (IDLE + 10) @(posedge clock);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h3, 32'h0);
    check({29'h0, cardOffline, parBusy, usbNack}, 32'h0);
    pop(8'h01);
    pop(8'h02);
  endtask
  task automatic throttleSteps();
    int i;
    for (i = 0; i < 9; i++) begin
      errorPresent <= thIn[i][20];
      bufFree <= thIn[i][19:0];
      repeat (3) @(posedge clock);
      apb(1'b0, REG_STATUS, 32'h0);
      check((rd >> 2) & 32'h3, {30'h0, thExp[i]});
    end
    bufFree <= FREE_RESUME_AT;
    repeat (3) @(posedge clock);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[3:2] == 2'h2}, 32'h0);
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic completeRun();
    if (mismatches == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    completeRun();
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, optCmdValid, rxReady, errorPresent} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 6'h00;
    optCmd = 8'h00;
    uCode = 8'h00;
    parStrobe = 1'b0;
    optValid = 1'b0;
    parData = 8'h00;
    optData = 8'h00;
    bufFree = 20'hfffff;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    afterReset();
    for (int i = 0; i < 34; i++) optSend(i == 33 ? 8'hff : i[7:0]);
    repeat (20) @(posedge clock);
    mainCommands();
    usbFifo();
    idleTimer();
    throttleSteps();
    completeRun();
  end
endmodule

/* verif/usb_host_model.sv */
// Behavioural USB host that offers bytes on the stream port.
`timescale 1ns/1ps
module usb_host_model (
  // Clock
  input wire logic clock,
  // Stream towards the selector
  input wire logic usbReady,
  output logic usbValid,
  output logic [7:0] usbData
);
  // Lines start idle.
  initial begin
    usbValid = 1'b0;
    usbData = 8'h00;
  end

  // Holds a byte until taken, then shows its inverse so no stale byte
  // can pass for a fresh one.
  task automatic send(input logic [7:0] b);
    @(posedge clock);
    usbValid <= 1'b1;
    usbData <= b;
    do @(posedge clock); while (usbReady !== 1'b1);
    usbValid <= 1'b0;
    usbData <= ~b;
  endtask
endmodule
